// ===== rtl/clock_panel_cfg.sv
/*
 * Clock and panel configuration register group of a display
 * controller: decodes stored settings into clock-tree, pixel-format
 * and timing controls. Assumes a single 40 MHz register clock.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps

module clock_panel_cfg
   import cfg_regs_pkg::*;
(
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_n_in,
   input  wire logic [cfg_regs_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [cfg_regs_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                          wr_in,
   input  wire logic                          rd_in,
   input  wire logic                          mem_clk_enabled_in,
   input  wire logic [15:0]                   pixel_in,
   output logic [cfg_regs_pkg::DATA_W-1:0]    rdata_out,
   output logic [2:0]                         spread_depth_out,
   output logic                               spread_reserved_out,
   output logic                               mem_src_alt_out,
   output logic [1:0]                         sys_div_out,
   output logic                               ss_src_memclk_out,
   output logic                               ss_src_change_hazard_out,
   output logic [1:0]                         input_format_out,
   output logic [23:0]                        pixel_rgb888_out,
   output logic [4:0]                         lcd_bus_width_out,
   output logic [10:0]                        active_pixels_out
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   cfg_bus_if bus ();
   logic [7:0] spread_q;
   logic [7:0] clksrc_q;
   logic [7:0] panel_q;
   logic [7:0] hact_q;

   // Port onto the internal bus
   assign bus.addr  = addr_in;
   assign bus.wdata = wdata_in;
   assign bus.wr    = wr_in;
   assign bus.rd    = rd_in;

   cfg_reg_file u_regs (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .bus        (bus),
      .spread_q   (spread_q),
      .clksrc_q   (clksrc_q),
      .panel_q    (panel_q),
      .hact_q     (hact_q)
   );

   assign rdata_out = bus.rdata;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] fmt_decode(input logic [1:0] f);
      fmt_decode = f[1] ? FMT_RGB565 : f;
   endfunction

   function automatic logic [23:0] to_rgb888(input logic [1:0]  f,
                                             input logic [15:0] p);
      logic [23:0] r;
      r = 24'h00_0000;
      case (f)
         FMT_RGB565:  r = {p[15:11], p[15:13], p[10:5], p[10:9],
                           p[4:0], p[4:2]};
         FMT_RGB888_B: r = {p[7:0], p[15:8], 8'h00};
         default:     r = {p[15:8], p[7:0], 8'h00};
      endcase
      to_rgb888 = r;
   endfunction

   // ----------------------------------------------------------------
   // Clock tree controls
   // ----------------------------------------------------------------
   // Spread depth and reserved-code flag
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spread_depth_out    <= 3'h4;
         spread_reserved_out <= 1'b0;
      end else begin
         spread_depth_out    <= spread_q[SPREAD_W_MSB:SPREAD_W_LSB];
         spread_reserved_out <= spread_q[SPREAD_W_MSB:SPREAD_W_LSB] > 3'h4;
      end
   end

   // Clock source and divider selection
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_src_alt_out   <= 1'b0;
         sys_div_out       <= SYS_DIV_BY3;
         ss_src_memclk_out <= 1'b0;
      end else begin
         mem_src_alt_out   <= clksrc_q[MEM_SRC_BIT];
         sys_div_out       <= clksrc_q[SYS_DIV_BIT] ? SYS_DIV_BY2 : SYS_DIV_BY3;
         ss_src_memclk_out <= clksrc_q[SS_SRC_MSB];
      end
   end

   // Flags a source rewrite while the memory clock still runs
   logic [1:0] ss_src_prev_q;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ss_src_prev_q            <= 2'b00;
         ss_src_change_hazard_out <= 1'b0;
      end else begin
         ss_src_prev_q <= clksrc_q[1:0];
         if (ss_src_prev_q != clksrc_q[1:0] && mem_clk_enabled_in)
            ss_src_change_hazard_out <= 1'b1;
         else if (!mem_clk_enabled_in)
            ss_src_change_hazard_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pixel path and panel
   // ----------------------------------------------------------------
   // Format decode and conversion to stored RGB888
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         input_format_out <= FMT_RGB888_A;
         pixel_rgb888_out <= 24'h00_0000;
      end else begin
         input_format_out <= fmt_decode(panel_q[IN_FMT_MSB:IN_FMT_LSB]);
         pixel_rgb888_out <= to_rgb888(fmt_decode(panel_q[IN_FMT_MSB:IN_FMT_LSB]),
                                       pixel_in);
      end
   end

   // Bus width and active width
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lcd_bus_width_out <= LCD_BUS_24;
         active_pixels_out <= 11'h008;
      end else begin
         lcd_bus_width_out <= panel_q[PANEL_WIDTH_BIT] ? LCD_BUS_18 : LCD_BUS_24;
         // Eleven bits: a full field of 127 gives 1024 pixels
         active_pixels_out <= 11'({4'b0000, hact_q[HACT_MSB:0]} + 11'h001)
                              << PIX_PER_UNIT_SHIFT;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   spread_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 spread_depth_out == $past(spread_q[6:4]))
      else $error("spread depth mismatch");
   spread_rsv_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      wr_in && addr_in == 8'h10 |=> spread_q[7] == 1'b0)
      else $error("spread bit 7 set");
   sys_div_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      clksrc_q[4] |=> sys_div_out == 2'h2)
      else $error("divider wrong");
   ss_src_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      clksrc_q[1] |=> ss_src_memclk_out)
      else $error("ss source wrong");
   fmt_565_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      panel_q[2] |=> input_format_out == 2'b10)
      else $error("format decode wrong");
   bus_width_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      panel_q[0] |=> lcd_bus_width_out == LCD_BUS_18)
      else $error("bus width wrong");
   hact_calc_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ##1 active_pixels_out == ($past(11'(hact_q[6:0])) + 11'h001) * 11'h008)
      else $error("active width wrong");
   rd_unmapped_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      rd_in && addr_in == 8'h11 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");

endmodule

// ===== rtl/cfg_regs_pkg.sv
/*
 * Package for the clock and panel configuration register group:
 * offsets, field positions, reset values and decoded mode types.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
package cfg_regs_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SPREAD_WIDTH_CONTROL_OFS    = 8'h10;
   localparam logic [7:0] CLOCK_SOURCE_SELECT_OFS     = 8'h12;
   localparam logic [7:0] PANEL_TYPE_CONFIG_OFS       = 8'h14;
   localparam logic [7:0] HORIZONTAL_ACTIVE_WIDTH_OFS = 8'h16;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SPREAD_W_LSB       = 4;
   localparam int SPREAD_W_MSB       = 6;
   localparam int SPREAD_RSV_MSB     = 3;
   localparam int MEM_SRC_BIT        = 7;
   localparam int SYS_DIV_BIT        = 4;
   localparam int SS_SRC_MSB         = 1;
   localparam int IN_FMT_LSB         = 1;
   localparam int IN_FMT_MSB         = 2;
   localparam int PANEL_WIDTH_BIT    = 0;
   localparam int HACT_MSB           = 6;

   // ----------------------------------------------------------------
   // Reset values and write masks
   // ----------------------------------------------------------------
   localparam logic [7:0] SPREAD_WIDTH_RESET = 8'h41;
   localparam logic [7:0] SPREAD_WIDTH_MASK  = 8'h7F;
   localparam logic [7:0] CLOCK_SRC_RESET    = 8'h00;
   localparam logic [7:0] CLOCK_SRC_MASK     = 8'h93;
   localparam logic [7:0] PANEL_TYPE_RESET   = 8'h00;
   localparam logic [7:0] PANEL_TYPE_MASK    = 8'h07;
   localparam logic [7:0] HACT_RESET         = 8'h00;
   localparam logic [7:0] HACT_MASK          = 8'h7F;
   localparam logic [3:0] SPREAD_RSV_PATTERN = 4'h1;

   // ----------------------------------------------------------------
   // Decoded modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SPREAD_0P25     = 3'b000,
      SPREAD_0P35     = 3'b001,
      SPREAD_0P45     = 3'b010,
      SPREAD_0P55     = 3'b011,
      SPREAD_0P65     = 3'b100,
      SPREAD_RESERVED = 3'b111
   } spread_depth_type;

   typedef enum logic [1:0] {
      FMT_RGB888_A = 2'b00,
      FMT_RGB888_B = 2'b01,
      FMT_RGB565   = 2'b10
   } input_format_type;

   typedef enum logic [1:0] {
      SS_SRC_NONE0  = 2'b00,
      SS_SRC_NONE1  = 2'b01,
      SS_SRC_MEMCLK = 2'b10
   } ss_source_type;

   localparam logic [1:0] SYS_DIV_BY3 = 2'h3;
   localparam logic [1:0] SYS_DIV_BY2 = 2'h2;
   localparam logic [4:0] LCD_BUS_24  = 5'h18;
   localparam logic [4:0] LCD_BUS_18  = 5'h12;
   localparam int         PIX_PER_UNIT_SHIFT = 3;

endpackage

// ===== rtl/cfg_bus_if.sv
/*
 * Interface carrying the register port between the top and its
 * register file. Assumes one clock and single-cycle strobes.
 */
`timescale 1ns/1ps
interface cfg_bus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;

   modport master (output addr, output wdata, output wr, output rd,
                   input rdata);
   modport slave  (input addr, input wdata, input wr, input rd,
                   output rdata);
endinterface

// ===== rtl/cfg_reg_file.sv
/*
 * Register storage for the four configuration registers, with a
 * registered read port. Assumes strobes never overlap.
 */
`timescale 1ns/1ps
module cfg_reg_file
   import cfg_regs_pkg::*;
(
   input  wire logic   clk_sys_in,
   input  wire logic   rst_n_in,
   cfg_bus_if.slave    bus,
   output logic [7:0]  spread_q,
   output logic [7:0]  clksrc_q,
   output logic [7:0]  panel_q,
   output logic [7:0]  hact_q
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] decode(input logic [7:0] a);
      decode = {a == HORIZONTAL_ACTIVE_WIDTH_OFS, a == PANEL_TYPE_CONFIG_OFS,
                a == CLOCK_SOURCE_SELECT_OFS, a == SPREAD_WIDTH_CONTROL_OFS};
   endfunction

   logic [3:0] sel;
   assign sel = decode(bus.addr);

   // Writes; unused bits masked off
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         spread_q <= SPREAD_WIDTH_RESET;
         clksrc_q <= CLOCK_SRC_RESET;
         panel_q  <= PANEL_TYPE_RESET;
         hact_q   <= HACT_RESET;
      end else if (bus.wr) begin
         if (sel[0]) spread_q <= bus.wdata & SPREAD_WIDTH_MASK;
         if (sel[1]) clksrc_q <= bus.wdata & CLOCK_SRC_MASK;
         if (sel[2]) panel_q  <= bus.wdata & PANEL_TYPE_MASK;
         if (sel[3]) hact_q   <= bus.wdata & HACT_MASK;
      end
   end

   // Read data registered, zero for unmapped addresses
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (1'b1)
            sel[0]:  bus.rdata <= spread_q;
            sel[1]:  bus.rdata <= clksrc_q;
            sel[2]:  bus.rdata <= panel_q;
            sel[3]:  bus.rdata <= hact_q;
            default: bus.rdata <= 8'h00;
         endcase
      end else begin
         bus.rdata <= 8'h00;
      end
   end

endmodule

// ===== verification/test_clock_panel_cfg.sv
/*
 * Self-checking bench for the clock and panel configuration group.
 * Assumes the top answers reads one cycle later and never stalls.
 */
`timescale 1ns/1ps
module test_clock_panel_cfg;
   import cfg_regs_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in   = 1'b0;
   logic [7:0]  addr_in    = 8'h00;
   logic [7:0]  wdata_in   = 8'h00;
   logic        wr_in      = 1'b0;
   logic        rd_in      = 1'b0;
   logic        mem_clk_enabled_in = 1'b0;
   logic [15:0] pixel_in   = 16'h0000;
   logic [7:0]  rdata_out;
   logic [2:0]  spread_depth_out;
   logic        spread_reserved_out;
   logic        mem_src_alt_out;
   logic [1:0]  sys_div_out;
   logic        ss_src_memclk_out;
   logic        ss_src_change_hazard_out;
   logic [1:0]  input_format_out;
   logic [23:0] pixel_rgb888_out;
   logic [4:0]  lcd_bus_width_out;
   logic [10:0] active_pixels_out;
   int          mismatches = 0;
   int          tests_run  = 0;

   clock_panel_cfg clock_panel_cfg_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .mem_clk_enabled_in(mem_clk_enabled_in), .pixel_in(pixel_in),
      .rdata_out(rdata_out), .spread_depth_out(spread_depth_out),
      .spread_reserved_out(spread_reserved_out), .mem_src_alt_out(mem_src_alt_out),
      .sys_div_out(sys_div_out), .ss_src_memclk_out(ss_src_memclk_out),
      .ss_src_change_hazard_out(ss_src_change_hazard_out),
      .input_format_out(input_format_out), .pixel_rgb888_out(pixel_rgb888_out),
      .lcd_bus_width_out(lcd_bus_width_out), .active_pixels_out(active_pixels_out));

   // 40 MHz register clock; spreading is never switched on here
   always #12.5 clk_sys_in = ~clk_sys_in;

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   // Compare and count
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Write strobe, left high so writes can run back to back
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      rd_in    <= 1'b0;
   endtask

   // Release strobes at the edge that takes the last request
   task automatic idle();
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
   endtask

   // Decoded outputs land one edge after the write is taken; wait two edges
   task automatic settle();
      repeat (2) @(posedge clk_sys_in);
      #1;
   endtask

   // Read; data stands one cycle, then returns to zero
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      wr_in   <= 1'b0;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1;
      check("rdata", {16'h0000, rdata_out}, {16'h0000, exp});
      @(posedge clk_sys_in);
      #1;
      check("rdata idle", {16'h0000, rdata_out}, 24'h00_0000);
   endtask

   // Write, release, wait for decoded outputs
   task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
      wr_reg(a, d);
      idle();
      settle();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      rd_reg(SPREAD_WIDTH_CONTROL_OFS, 8'h41);
      rd_reg(CLOCK_SOURCE_SELECT_OFS, 8'h00);
      rd_reg(PANEL_TYPE_CONFIG_OFS, 8'h00);
      rd_reg(HORIZONTAL_ACTIVE_WIDTH_OFS, 8'h00);
      check("depth", 24'(spread_depth_out), 24'h00_0004);
      check("sysdiv", 24'(sys_div_out), 24'h00_0003);
      check("lcd", 24'(lcd_bus_width_out), 24'h00_0018);
      check("pixels", 24'(active_pixels_out), 24'h00_0008);
      check("format", 24'(input_format_out), 24'h00_0000);
      check("mem src", 24'(mem_src_alt_out), 24'h00_0000);
      $display("test_reset done");
   endtask

   task automatic test_spread();
      for (int i = 0; i < 8; i++) begin
         wr_settle(SPREAD_WIDTH_CONTROL_OFS, {1'b0, 3'(i), 4'h1});
         check("depth", 24'(spread_depth_out), 24'(i));
         check("reserved", 24'(spread_reserved_out), 24'(i > 4));
      end
      wr_reg(SPREAD_WIDTH_CONTROL_OFS, 8'hFF);
      rd_reg(SPREAD_WIDTH_CONTROL_OFS, 8'h7F);
      wr_reg(SPREAD_WIDTH_CONTROL_OFS, 8'h41);
      idle();
      $display("test_spread done");
   endtask

   task automatic test_clock();
      wr_settle(CLOCK_SOURCE_SELECT_OFS, 8'h10);
      check("sysdiv", 24'(sys_div_out), 24'h00_0002);
      for (int i = 0; i < 4; i++) begin
         wr_settle(CLOCK_SOURCE_SELECT_OFS, 8'(i));
         check("sysdiv", 24'(sys_div_out), 24'h00_0003);
         check("ss src", 24'(ss_src_memclk_out), 24'(i >> 1));
         check("hazard", 24'(ss_src_change_hazard_out), 24'h00_0000);
      end
      wr_reg(CLOCK_SOURCE_SELECT_OFS, 8'hFF);
      rd_reg(CLOCK_SOURCE_SELECT_OFS, 8'h93);
      check("mem src", 24'(mem_src_alt_out), 24'h00_0001);
      wr_settle(CLOCK_SOURCE_SELECT_OFS, 8'h00);
      // Source rewritten with the memory clock still running
      @(posedge clk_sys_in);
      mem_clk_enabled_in <= 1'b1;
      wr_settle(CLOCK_SOURCE_SELECT_OFS, 8'h02);
      @(posedge clk_sys_in);
      #1;
      check("hazard", 24'(ss_src_change_hazard_out), 24'h00_0001);
      @(posedge clk_sys_in);
      mem_clk_enabled_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      check("hazard", 24'(ss_src_change_hazard_out), 24'h00_0000);
      $display("test_clock done");
   endtask

   task automatic test_panel();
      for (int i = 0; i < 8; i++) begin
         wr_settle(PANEL_TYPE_CONFIG_OFS, 8'(i));
         check("format", 24'(input_format_out), (i >= 4) ? 24'h00_0002 : 24'(i >> 1));
         check("lcd", 24'(lcd_bus_width_out), 24'((i % 2) ? LCD_BUS_18 : LCD_BUS_24));
         @(posedge clk_sys_in);
         pixel_in <= 16'hA5C3;
         @(posedge clk_sys_in);
         #1;
         if (i < 2)
            check("rgb888", pixel_rgb888_out, 24'hA5_C300);
         else if (i < 4)
            check("rgb888 swap", pixel_rgb888_out, 24'hC3_A500);
         else begin
            check("red", 24'(pixel_rgb888_out[23:19]), 24'h00_0014);
            check("green", 24'(pixel_rgb888_out[15:10]), 24'h00_002E);
            check("blue", 24'(pixel_rgb888_out[7:3]), 24'h00_0003);
         end
         rd_reg(PANEL_TYPE_CONFIG_OFS, 8'(i));
      end
      wr_reg(PANEL_TYPE_CONFIG_OFS, 8'hFF);
      rd_reg(PANEL_TYPE_CONFIG_OFS, 8'h07);
      $display("test_panel done");
   endtask

   task automatic test_hact();
      wr_settle(HORIZONTAL_ACTIVE_WIDTH_OFS, 8'h03);
      check("pixels", 24'(active_pixels_out), 24'h00_0020);
      wr_settle(HORIZONTAL_ACTIVE_WIDTH_OFS, 8'h77);
      check("pixels", 24'(active_pixels_out), 24'h00_03C0);
      wr_settle(HORIZONTAL_ACTIVE_WIDTH_OFS, 8'hFF);
      check("pixels", 24'(active_pixels_out), 24'h00_0400);
      rd_reg(HORIZONTAL_ACTIVE_WIDTH_OFS, 8'h7F);
      // Unmapped place takes nothing and reads zero
      wr_reg(8'h11, 8'hFF);
      rd_reg(8'h11, 8'h00);
      rd_reg(SPREAD_WIDTH_CONTROL_OFS, 8'h41);
      $display("test_hact done");
   endtask

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog well beyond the two hundred or so cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      mismatches++;
      summarize();
   end

   // Reset for four cycles, then the scenarios
   initial begin
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      test_reset();
      test_spread();
      test_clock();
      test_panel();
      test_hact();
      summarize();
   end
endmodule
